// ==== rtl/cvpi_defines.svh ====
`ifndef CVPI_DEFINES_SVH
`define CVPI_DEFINES_SVH

// clock and flash time base
`define CVPI_CLK_HZ      100000000
`define CVPI_TICK_MS     10
`define CVPI_TICK_CYC    (`CVPI_CLK_HZ / 1000 * `CVPI_TICK_MS)

// flash segment times in ms
`define CVPI_BRIEF_MS    50
`define CVPI_GAP_MS      950
`define CVPI_QUICK_MS    50
`define CVPI_STEADY_MS   1000
`define CVPI_SLOW_MS     500
`define CVPI_LONG_MS     600
`define CVPI_SHORT_MS    200
`define CVPI_PAUSE_MS    800

// keypad numbers
`define CVPI_KEY_ZERO    7'h50
`define CVPI_KEY_LIMIT   8'h50
`define CVPI_LONG_KEY    7'h07
`define CVPI_BYTE_MAX    10'h0FF

// indirect helper variables
`define CVPI_CV_HUND     10'h060
`define CVPI_CV_LOW      10'h061
`define CVPI_CV_VAL      10'h063
`define CVPI_HUND_MAX    8'h09
`define CVPI_LOW_MAX     8'h63
`define CVPI_HELPER_RST  8'h00
`define CVPI_CV_MAX      1023

`endif

// ==== rtl/cvpi_pkg.sv ====
package cvpi_pkg;

	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_KEY,
		CMD_DIR,
		CMD_WRITE
	} cvpi_kind_t;

	typedef struct packed {
		cvpi_kind_t  kind;
		logic [9:0]  num;
		logic [7:0]  data;
	} cvpi_cmd_t;

	typedef struct packed {
		logic        vld;
		logic [9:0]  num;
		logic [7:0]  data;
	} cvpi_wr_t;

	typedef enum logic [2:0] {
		PAT_OFF,
		PAT_BRIEF,
		PAT_TWICE,
		PAT_STEADY,
		PAT_SLOW,
		PAT_LS,
		PAT_LSS,
		PAT_LSSS
	} cvpi_pat_t;

	typedef struct packed {
		logic        on;
		logic [7:0]  ticks;
		logic        last;
	} cvpi_seg_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_S_CV,
		ST_S_VAL,
		ST_L_CVH,
		ST_L_CVU,
		ST_L_VH,
		ST_L_VU
	} cvpi_state_t;

endpackage

// ==== rtl/cvpi_sync.sv ====
`timescale 1ns/1ps
module cvpi_sync (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// a change counts once the second and third stage agree
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				o_level <= s3_r;
			end
		end
	end
endmodule // cvpi_sync

// ==== rtl/cvpi_flash.sv ====
`timescale 1ns/1ps
`include "cvpi_defines.svh"
module cvpi_flash #(
	parameter int TICK_CYC = `CVPI_TICK_CYC
) (
	input  wire logic                i_clk,
	input  wire logic                i_nrst,
	input  wire cvpi_pkg::cvpi_pat_t i_bg,
	input  wire logic                i_shot_vld,
	input  wire cvpi_pkg::cvpi_pat_t i_shot,
	output logic                     o_lamp
);
	import cvpi_pkg::*;

	localparam int PW = $clog2(TICK_CYC);

	initial begin
		if (TICK_CYC < 2) begin
			$error("cvpi_flash: TICK_CYC must be at least 2");
		end
	end

	logic [PW-1:0] pre_r;
	logic          tick;
	cvpi_pat_t     pat_r;
	logic          shot_r;
	logic [3:0]    idx_r;
	logic [7:0]    cnt_r;
	cvpi_seg_t     seg;

	function automatic logic [7:0] ms2t(input int ms);
		return 8'(ms / `CVPI_TICK_MS);
	endfunction

	// segment table: lamp level, length in ticks, end of pattern
	function automatic cvpi_seg_t seg_of(input cvpi_pat_t p,
		input logic [3:0] i);
		cvpi_seg_t s;
		logic [3:0] n;
		s = '{on: 1'b0, ticks: 8'h01, last: 1'b1};
		n = 4'h0;
		case (p)
			PAT_BRIEF: begin
				s = '{on: (i == 4'h0), last: (i != 4'h0),
					ticks: (i == 4'h0) ? ms2t(`CVPI_BRIEF_MS)
					: ms2t(`CVPI_GAP_MS)};
			end
			PAT_TWICE: begin
				s = '{on: ~i[0], ticks: ms2t(`CVPI_QUICK_MS),
					last: (i == 4'h3)};
			end
			PAT_STEADY: begin
				s = '{on: 1'b1, ticks: ms2t(`CVPI_STEADY_MS),
					last: 1'b1};
			end
			PAT_SLOW: begin
				s = '{on: ~i[0], ticks: ms2t(`CVPI_SLOW_MS),
					last: i[0]};
			end
			PAT_LS, PAT_LSS, PAT_LSSS: begin
				n = (p == PAT_LS) ? 4'h1 : (p == PAT_LSS) ? 4'h2 : 4'h3;
				if (i == 4'h0) begin
					s = '{on: 1'b1, ticks: ms2t(`CVPI_LONG_MS),
						last: 1'b0};
				end else if (i == 4'((n << 1) + 4'h1)) begin
					s = '{on: 1'b0, ticks: ms2t(`CVPI_PAUSE_MS),
						last: 1'b1};
				end else begin
					s = '{on: ~i[0], ticks: ms2t(`CVPI_SHORT_MS),
						last: 1'b0};
				end
			end
			default: begin
				s = '{on: 1'b0, ticks: 8'h01, last: 1'b1};
			end
		endcase
		return s;
	endfunction

	assign seg  = seg_of(pat_r, idx_r);
	assign tick = (pre_r == PW'(TICK_CYC - 1));

	// tick prescaler, restarted with each one-shot pattern
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pre_r <= '0;
		end else if (i_shot_vld || tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PW'(1);
		end
	end

	// pattern player: one-shot first, then the background loop
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pat_r  <= PAT_OFF;
			shot_r <= 1'b0;
			idx_r  <= 4'h0;
			cnt_r  <= 8'h00;
		end else if (i_shot_vld) begin
			pat_r  <= i_shot;
			shot_r <= 1'b1;
			idx_r  <= 4'h0;
			cnt_r  <= 8'h00;
		end else if (!shot_r && pat_r != i_bg) begin
			pat_r <= i_bg;
			idx_r <= 4'h0;
			cnt_r <= 8'h00;
		end else if (tick) begin
			if (cnt_r + 8'h01 >= seg.ticks) begin
				cnt_r <= 8'h00;
				idx_r <= seg.last ? 4'h0 : idx_r + 4'h1;
				if (seg.last && shot_r) begin
					shot_r <= 1'b0;
					pat_r  <= i_bg;
				end
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_lamp <= 1'b0;
		end else begin
			o_lamp <= seg.on;
		end
	end
endmodule // cvpi_flash

// ==== rtl/cvpi_top.sv ====
// Functional notes
// - short mode: numbers and values below 80
// - long mode: full byte, split entries
// - no read-back during keypad programming
// - keypad 80 stands for zero
// - address 80 enters programming as first command after power returns
// - short mode waiting: brief periodic flashes
// - short mode number latched, two quick flashes
// - value stored, lamps steady one second
// - number 80 or power cycle exits
// - value 07 into 07 enters long mode
// - long mode number in two confirmed parts
// - long mode value in two confirmed parts
// - long mode left only by power cycle
// - helpers hold hundreds and low digits
// - helper value write commits to target
// - helpers cleared after indirect write
`timescale 1ns/1ps
`include "cvpi_defines.svh"
module cvpi_top #(
	parameter int TICK_CYC = `CVPI_TICK_CYC,
	parameter int CV_MAX   = `CVPI_CV_MAX
) (
	input  wire logic                I_CLK,
	input  wire logic                I_NRST,
	input  wire logic                I_TRACK_PWR,
	input  wire logic [6:0]          I_OWN_ADDR,
	input  wire logic                I_CMD_VLD,
	input  wire cvpi_pkg::cvpi_cmd_t I_CMD,
	input  wire logic                I_RD_VLD,
	input  wire logic [9:0]          I_RD_NUM,
	output cvpi_pkg::cvpi_wr_t       O_CV_WR,
	output logic                     O_LAMP,
	output logic                     O_PROG,
	output logic                     O_LONG,
	output logic                     O_RD_ACK,
	output logic                     O_RD_HIT,
	output logic [7:0]               O_RD_DATA
);
	import cvpi_pkg::*;

	initial begin
		if (CV_MAX < 1 || CV_MAX > 1023) begin
			$error("cvpi_top: CV_MAX must lie in 1..1023");
		end
	end

	////////////////////////////////////////////////////////////////
	// declarations

	logic        pwr_s;
	logic        pwr_q_r;
	logic        pwr_rise;
	logic        pwr_fall;
	logic        arm_r;
	logic        enter_ok;
	logic        is_dir;
	logic        is_key;

	cvpi_state_t st_r;
	cvpi_state_t st_nxt;
	logic [6:0]  pend_r;
	logic [6:0]  pend_nxt;
	logic [9:0]  cvn_r;
	logic [9:0]  cvn_nxt;
	logic [6:0]  ht_r;
	logic [6:0]  ht_nxt;
	logic [6:0]  kv;
	logic [9:0]  sum;

	cvpi_wr_t    kp_wr;
	cvpi_wr_t    req;
	logic        shot_vld;
	cvpi_pat_t   shot;
	cvpi_pat_t   bg;

	logic [7:0]  hund_r;
	logic [7:0]  low_r;
	logic [9:0]  tgt;
	logic        tgt_ok;

	////////////////////////////////////////////////////////////////
	// functions

	// keypad cannot send zero, so 80 stands for it
	function automatic logic [6:0] key_val(input logic [6:0] k);
		return (k == `CVPI_KEY_ZERO) ? 7'h00 : k;
	endfunction

	function automatic logic is_helper(input logic [9:0] n);
		return (n == `CVPI_CV_HUND) || (n == `CVPI_CV_LOW)
			|| (n == `CVPI_CV_VAL);
	endfunction

	function automatic logic [9:0] tens_units(input logic [6:0] h,
		input logic [6:0] u);
		return 10'(10'(h) * 10'h00A + 10'(u));
	endfunction

	////////////////////////////////////////////////////////////////
	// track power

	cvpi_sync u_pwr_sync (
		.i_clk   (I_CLK),
		.i_nrst  (I_NRST),
		.i_async (I_TRACK_PWR),
		.o_level (pwr_s)
	);

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pwr_q_r <= 1'b0;
		end else begin
			pwr_q_r <= pwr_s;
		end
	end

	assign pwr_rise = pwr_s & ~pwr_q_r;
	assign pwr_fall = ~pwr_s & pwr_q_r;

	// only the first command after power returns may open programming
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			arm_r <= 1'b0;
		end else if (pwr_rise) begin
			arm_r <= 1'b1;
		end else if (I_CMD_VLD || pwr_fall) begin
			arm_r <= 1'b0;
		end
	end

	assign is_dir = I_CMD_VLD && (I_CMD.kind == CMD_DIR);
	assign is_key = I_CMD_VLD && (I_CMD.kind == CMD_KEY);

	// direction held while power returns, own address or 80
	assign enter_ok = arm_r && is_dir && I_CMD.num[9:7] == 3'h0
		&& (I_CMD.num[6:0] == I_OWN_ADDR
		|| I_CMD.num[6:0] == `CVPI_KEY_ZERO);

	////////////////////////////////////////////////////////////////
	// keypad procedure

	assign kv  = key_val(pend_r);
	assign sum = tens_units(ht_r, kv);

	always_comb begin
		st_nxt   = st_r;
		pend_nxt = pend_r;
		cvn_nxt  = cvn_r;
		ht_nxt   = ht_r;
		kp_wr    = '0;
		shot_vld = 1'b0;
		shot     = PAT_OFF;
		if (pwr_fall) begin
			st_nxt = ST_OFF;
		end else if (is_key && st_r != ST_OFF) begin
			pend_nxt = I_CMD.num[6:0];
		end else if (is_dir) begin
			case (st_r)
				ST_OFF: begin
					if (enter_ok) begin
						st_nxt   = ST_S_CV;
						pend_nxt = 7'h00;
					end
				end
				ST_S_CV: begin
					if (pend_r == `CVPI_KEY_ZERO) begin
						st_nxt = ST_OFF;
					end else begin
						cvn_nxt  = 10'(kv);
						st_nxt   = ST_S_VAL;
						shot_vld = 1'b1;
						shot     = PAT_TWICE;
					end
				end
				ST_S_VAL: begin
					if (cvn_r == 10'(`CVPI_LONG_KEY)
						&& kv == `CVPI_LONG_KEY) begin
						st_nxt = ST_L_CVH;
					end else begin
						st_nxt = ST_S_CV;
						if (cvn_r < 10'(`CVPI_KEY_LIMIT)
							&& {1'b0, kv} < `CVPI_KEY_LIMIT) begin
							kp_wr    = '{vld: 1'b1, num: cvn_r,
								data: {1'b0, kv}};
							shot_vld = 1'b1;
							shot     = PAT_STEADY;
						end
					end
				end
				ST_L_CVH: begin
					ht_nxt = kv;
					st_nxt = ST_L_CVU;
				end
				ST_L_CVU: begin
					cvn_nxt = sum;
					st_nxt  = ST_L_VH;
				end
				ST_L_VH: begin
					ht_nxt = kv;
					st_nxt = ST_L_VU;
				end
				ST_L_VU: begin
					st_nxt = ST_L_CVH;
					if (sum <= `CVPI_BYTE_MAX) begin
						kp_wr    = '{vld: 1'b1, num: cvn_r,
							data: sum[7:0]};
						shot_vld = 1'b1;
						shot     = PAT_STEADY;
					end
				end
				default: begin
					st_nxt = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_r   <= ST_OFF;
			pend_r <= 7'h00;
			cvn_r  <= 10'h000;
			ht_r   <= 7'h00;
		end else begin
			st_r   <= st_nxt;
			pend_r <= pend_nxt;
			cvn_r  <= cvn_nxt;
			ht_r   <= ht_nxt;
		end
	end

	assign O_PROG = (st_r != ST_OFF);
	assign O_LONG = O_PROG && (st_r != ST_S_CV) && (st_r != ST_S_VAL);

	////////////////////////////////////////////////////////////////
	// headlight patterns

	always_comb begin
		case (st_r)
			ST_OFF:   bg = PAT_OFF;
			ST_S_CV:  bg = PAT_BRIEF;
			ST_S_VAL: bg = PAT_BRIEF;
			ST_L_CVH: bg = PAT_SLOW;
			ST_L_CVU: bg = PAT_LS;
			ST_L_VH:  bg = PAT_LSS;
			ST_L_VU:  bg = PAT_LSSS;
			default:  bg = PAT_OFF;
		endcase
	end

	cvpi_flash #(
		.TICK_CYC (TICK_CYC)
	) u_flash (
		.i_clk      (I_CLK),
		.i_nrst     (I_NRST),
		.i_bg       (bg),
		.i_shot_vld (shot_vld),
		.i_shot     (shot),
		.o_lamp     (O_LAMP)
	);

	////////////////////////////////////////////////////////////////
	// variable writes and indirect helpers

	always_comb begin
		if (kp_wr.vld) begin
			req = kp_wr;
		end else if (I_CMD_VLD && I_CMD.kind == CMD_WRITE) begin
			req = '{vld: 1'b1, num: I_CMD.num, data: I_CMD.data};
		end else begin
			req = '0;
		end
	end

	// target is hundreds times 100 plus the low digits
	assign tgt = 10'(10'(hund_r[3:0]) * 10'h064 + 10'(low_r[6:0]));
	assign tgt_ok = (hund_r <= `CVPI_HUND_MAX) && (low_r <= `CVPI_LOW_MAX)
		&& (int'(tgt) <= CV_MAX);

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			hund_r <= `CVPI_HELPER_RST;
			low_r  <= `CVPI_HELPER_RST;
		end else if (req.vld) begin
			case (req.num)
				`CVPI_CV_HUND: hund_r <= req.data;
				`CVPI_CV_LOW:  low_r  <= req.data;
				`CVPI_CV_VAL: begin
					hund_r <= `CVPI_HELPER_RST;
					low_r  <= `CVPI_HELPER_RST;
				end
				default: begin
					hund_r <= hund_r;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_CV_WR <= '0;
		end else if (req.vld && req.num == `CVPI_CV_VAL) begin
			O_CV_WR <= '{vld: tgt_ok, num: tgt,
				data: req.data};
		end else if (req.vld && !is_helper(req.num)
			&& int'(req.num) <= CV_MAX) begin
			O_CV_WR <= req;
		end else begin
			O_CV_WR <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// helper read-back, refused while keypad programming runs

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RD_ACK  <= 1'b0;
			O_RD_HIT  <= 1'b0;
			O_RD_DATA <= 8'h00;
		end else begin
			O_RD_ACK <= I_RD_VLD;
			O_RD_HIT <= I_RD_VLD && !O_PROG && is_helper(I_RD_NUM);
			if (I_RD_VLD && !O_PROG) begin
				case (I_RD_NUM)
					`CVPI_CV_HUND: O_RD_DATA <= hund_r;
					`CVPI_CV_LOW:  O_RD_DATA <= low_r;
					default:       O_RD_DATA <= 8'h00;
				endcase
			end else begin
				O_RD_DATA <= 8'h00;
			end
		end
	end

endmodule // cvpi_top

// ==== testbench/cvpi_monitor.sv ====
`timescale 1ns/1ps
module cvpi_monitor #(
	parameter int TICK_CYC = 4,
	parameter int CV_MAX   = 1023
) (
	input wire logic                I_CLK,
	input wire logic                I_NRST,
	input wire logic                I_TRACK_PWR,
	input wire logic                I_CMD_VLD,
	input wire cvpi_pkg::cvpi_cmd_t I_CMD,
	input wire logic                I_RD_VLD,
	input wire logic [9:0]          I_RD_NUM,
	input wire cvpi_pkg::cvpi_wr_t  O_CV_WR,
	input wire logic                O_PROG,
	input wire logic                O_LONG,
	input wire logic                O_RD_ACK,
	input wire logic                O_RD_HIT,
	input wire logic [7:0]          O_RD_DATA
);
	import cvpi_pkg::*;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	chk_wr_pulse: assert property (O_CV_WR.vld && !I_CMD_VLD
		|=> !O_CV_WR.vld) else $error("store strobe longer than one cycle");
	chk_key_nowr: assert property (I_CMD_VLD && I_CMD.kind == CMD_KEY
		|=> !O_CV_WR.vld) else $error("key entry alone caused a store");
	chk_short_range: assert property (O_PROG && !O_LONG && O_CV_WR.vld
		|-> O_CV_WR.num < 10'h050 && O_CV_WR.data < 8'h50)
		else $error("short mode store out of range");
	chk_long_prog: assert property (O_LONG |-> O_PROG)
		else $error("long mode outside programming");
	chk_long_hold: assert property (I_TRACK_PWR [*6] ##0 O_LONG
		|=> O_LONG) else $error("long mode left without power loss");
	chk_rd_ack: assert property (O_RD_ACK == $past(I_RD_VLD))
		else $error("read acknowledge wrong");
	chk_rd_refuse: assert property (I_RD_VLD && O_PROG
		|=> !O_RD_HIT && O_RD_DATA == 8'h00)
		else $error("read answered while programming");
	chk_rd_hund: assert property (I_RD_VLD && !O_PROG
		&& I_RD_NUM == 10'h060 |=> O_RD_HIT) else $error("helper read missed");
	chk_helper_wr: assert property (I_CMD_VLD && I_CMD.kind == CMD_WRITE
		&& I_CMD.num inside {10'h060, 10'h061} |=> !O_CV_WR.vld)
		else $error("helper write forwarded");
	chk_helper_clr: assert property (I_CMD_VLD && I_CMD.kind == CMD_WRITE
		&& I_CMD.num == 10'h063 ##[1:4] I_RD_VLD && !O_PROG
		&& I_RD_NUM == 10'h060 |=> O_RD_DATA == 8'h00)
		else $error("helper not cleared after commit");
endmodule // cvpi_monitor

bind cvpi_top cvpi_monitor #(.TICK_CYC(TICK_CYC), .CV_MAX(CV_MAX)) cvpi_monitor_i (
	.I_CLK(I_CLK), .I_NRST(I_NRST), .I_TRACK_PWR(I_TRACK_PWR),
	.I_CMD_VLD(I_CMD_VLD), .I_CMD(I_CMD), .I_RD_VLD(I_RD_VLD),
	.I_RD_NUM(I_RD_NUM), .O_CV_WR(O_CV_WR), .O_PROG(O_PROG), .O_LONG(O_LONG),
	.O_RD_ACK(O_RD_ACK), .O_RD_HIT(O_RD_HIT), .O_RD_DATA(O_RD_DATA));

// ==== testbench/cvpi_station.sv ====
`timescale 1ns/1ps
module cvpi_station (
	input  wire logic           i_clk,
	output logic                o_pwr,
	output logic                o_vld,
	output cvpi_pkg::cvpi_cmd_t o_cmd
);
	import cvpi_pkg::*;
	initial begin
		o_pwr = 1'b0;
		o_vld = 1'b0;
		o_cmd = '0;
	end
	task automatic power(input logic on);
		@(posedge i_clk);
		o_pwr <= on;
		repeat (8) @(posedge i_clk);
	endtask
	// idle command lines toggle so a stale value is never held
	task automatic send(input cvpi_kind_t k, input logic [9:0] n,
		input logic [7:0] d);
		@(posedge i_clk);
		o_vld <= 1'b1;
		o_cmd <= '{k, n, d};
		@(posedge i_clk);
		o_vld <= 1'b0;
		o_cmd <= ~o_cmd;
	endtask
	// power off, then back on with the direction change held
	task automatic enter(input logic [6:0] a);
		power(1'b0);
		power(1'b1);
		send(CMD_DIR, {3'h0, a}, 8'h00);
	endtask
	// keypad sends 1..80 only, so zero goes out as 80
	task automatic key(input int v);
		send(CMD_KEY, (v == 0) ? 10'h050 : 10'(v), 8'h00);
		send(CMD_DIR, 10'h050, 8'h00);
	endtask
endmodule // cvpi_station

// ==== testbench/cvpi_tb.sv ====
`timescale 1ns/1ps
module testbench;
	import cvpi_pkg::*;
	logic        clk;
	logic        nrst;
	logic        pwr, cmd_vld, rd_vld, rd_ack, rd_hit, lamp, prog, lng;
	logic [9:0]  rd_num;
	logic [7:0]  rd_data;
	cvpi_cmd_t   cmd;
	cvpi_wr_t    wr;
	logic [17:0] expq[$];
	int          miscompares, cmp_count, n, v, h, l;
	int          seed = 32'hab5f3cf9;
	logic [6:0]  own_addr;

	cvpi_top #(.TICK_CYC(4), .CV_MAX(500)) cvpi_top_i (
		.I_CLK(clk), .I_NRST(nrst), .I_TRACK_PWR(pwr), .I_OWN_ADDR(own_addr),
		.I_CMD_VLD(cmd_vld), .I_CMD(cmd), .I_RD_VLD(rd_vld), .I_RD_NUM(rd_num),
		.O_CV_WR(wr), .O_LAMP(lamp), .O_PROG(prog), .O_LONG(lng),
		.O_RD_ACK(rd_ack), .O_RD_HIT(rd_hit), .O_RD_DATA(rd_data));
	cvpi_station cvpi_station_i (.i_clk(clk), .o_pwr(pwr), .o_vld(cmd_vld),
		.o_cmd(cmd));

	always #5 clk = ~clk;

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic rd(input logic [9:0] num, input logic hit,
		input logic [7:0] d);
		@(posedge clk);
		rd_vld <= 1'b1;
		rd_num <= num;
		@(posedge clk);
		rd_vld <= 1'b0;
		@(posedge clk);
		check("rd_ack", rd_ack, 1'b1);
		check("rd_hit", rd_hit, hit);
		check("rd_data", rd_data, d);
	endtask

	task automatic push(input int cv, input int val);
		expq.push_back({10'(cv), 8'(val)});
	endtask

	// every store is matched against the oldest queued expectation
	always @(posedge clk) begin
		if (wr.vld === 1'b1) begin
			if (expq.size() == 0) check("stray_store", 1'b1, 1'b0);
			else check("store", {wr.num, wr.data}, expq.pop_front());
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_sim;
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		rd_vld = 1'b0;
		rd_num = 10'h000;
		own_addr = 7'(1 + $unsigned($random(seed)) % 79);
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		cvpi_station_i.power(1'b1);
		h = $unsigned($random(seed)) % 5;
		l = $unsigned($random(seed)) % 100;
		v = $unsigned($random(seed)) % 256;
		cvpi_station_i.send(CMD_WRITE, 10'h060, 8'(h));
		rd(10'h060, 1'b1, 8'(h));
		cvpi_station_i.send(CMD_WRITE, 10'h061, 8'(l));
		push(h * 100 + l, v);
		cvpi_station_i.send(CMD_WRITE, 10'h063, 8'(v));
		rd(10'h061, 1'b1, 8'h00);
		rd(10'h063, 1'b1, 8'h00);
		// target 999 lies beyond the last variable
		cvpi_station_i.send(CMD_WRITE, 10'h060, 8'h09);
		cvpi_station_i.send(CMD_WRITE, 10'h061, 8'h63);
		cvpi_station_i.send(CMD_WRITE, 10'h063, 8'h37);
		rd(10'h060, 1'b1, 8'h00);
		$display("test indirect done");
		cvpi_station_i.enter(7'h50);
		repeat (2) @(posedge clk);
		check("prog", prog, 1'b1);
		check("long", lng, 1'b0);
		rd(10'h060, 1'b0, 8'h00);
		check("lamp_brief", lamp, 1'b1);
		repeat (100) @(posedge clk);
		check("lamp_gap", lamp, 1'b0);
		for (int i = 0; i < 4; i++) begin
			n = 8 + $unsigned($random(seed)) % 72;
			v = (i == 0) ? 0 : 1 + $unsigned($random(seed)) % 79;
			cvpi_station_i.key(n);
			repeat (8) @(posedge clk);
			check("lamp_twice", lamp, 1'b1);
			push(n, v);
			cvpi_station_i.key(v);
			repeat (20) @(posedge clk);
			check("lamp_steady", lamp, 1'b1);
			repeat (330) @(posedge clk);
			check("lamp_steady", lamp, 1'b1);
			repeat (60) @(posedge clk);
		end
		cvpi_station_i.key(80);
		repeat (2) @(posedge clk);
		check("prog", prog, 1'b0);
		$display("test short done");
		// an address that is neither its own nor 80 is refused
		cvpi_station_i.enter(7'h7F);
		repeat (2) @(posedge clk);
		check("prog", prog, 1'b0);
		cvpi_station_i.enter(own_addr);
		cvpi_station_i.key(7);
		cvpi_station_i.key(7);
		repeat (2) @(posedge clk);
		check("long", lng, 1'b1);
		repeat (100) @(posedge clk);
		check("lamp_slow", lamp, 1'b1);
		repeat (200) @(posedge clk);
		check("lamp_slow", lamp, 1'b0);
		for (int i = 0; i < 3; i++) begin
			n = (i == 0) ? 124 : $unsigned($random(seed)) % 500;
			// helper numbers are not plain variables
			if (n inside {96, 97, 99}) n = n + 4;
			v = (i == 0) ? 135 : $unsigned($random(seed)) % 256;
			push(n, v);
			cvpi_station_i.key(n / 10);
			if (i == 0) begin
				repeat (8) @(posedge clk);
				check("lamp_ls", lamp, 1'b1);
				repeat (272) @(posedge clk);
				check("lamp_ls", lamp, 1'b0);
				repeat (80) @(posedge clk);
				check("lamp_ls", lamp, 1'b1);
			end
			cvpi_station_i.key(n % 10);
			cvpi_station_i.key(v / 10);
			cvpi_station_i.key(v % 10);
			repeat (450) @(posedge clk);
		end
		// value 300 does not fit a byte and must not be stored
		cvpi_station_i.key(1);
		cvpi_station_i.key(2);
		cvpi_station_i.key(30);
		cvpi_station_i.key(0);
		repeat (450) @(posedge clk);
		check("long", lng, 1'b1);
		cvpi_station_i.power(1'b0);
		check("prog", prog, 1'b0);
		check("long", lng, 1'b0);
		check("pending", expq.size(), 0);
		$display("test long done");
		end_sim;
	end
endmodule // testbench
